// >>> rtl/scd_pkg.sv
// Constants and types shared by the sample clock divider and direct-write block
package scd_pkg;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_TX_CFG = 8'h40;
   localparam logic [7:0] IDX_TRX_DIV = 8'h60;
   localparam logic [7:0] IDX_VOICE_DIV = 8'h61;
   localparam logic [7:0] IDX_DW_I_BASE = 8'h60;
   localparam logic [7:0] IDX_DW_Q_BASE = 8'h70;
   localparam logic [7:0] IDX_DW_LAST = 8'h7F;

   // Field positions
   localparam int CFG_DW_BIT = 5;
   localparam int DW_CHAN_BIT = 4;
   localparam int TX_CODE_LSB = 4;
   localparam int RX_CODE_LSB = 0;

   // Values after reset
   localparam logic [7:0] TX_CFG_RST = 8'h00;
   localparam logic [7:0] TRX_DIV_RST = 8'h00;
   localparam logic [7:0] VOICE_DIV_RST = 8'h07;

   // Divider arithmetic
   localparam logic [4:0] TRX_RATIO_OFS = 5'h04;
   localparam logic [3:0] TRX_CODE_MAX = 4'hC;
   localparam logic [4:0] TRX_RATIO_MAX = 5'h10;
   localparam logic [4:0] VOICE_RATIO_TOP = 5'h10;
   localparam logic [4:0] VOICE_RATIO_MIN = 5'h08;
   localparam int CNT_W = 12;
   localparam int SYM_PER_SMP = 8;
   localparam int SMP_W = 12;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      W_IDLE = 2'b00,
      W_EXEC = 2'b01,
      W_RESP = 2'b11
   } scd_wstate_t;

   typedef enum logic [2:0] {
      K_NONE,
      K_CFG,
      K_TRX,
      K_VOICE,
      K_DW
   } scd_kind_t;

endpackage

// >>> rtl/scd_stream_if.sv
// Valid/ready stream carrier between the register side and the sample buffer
`timescale 1ns/1ps
`default_nettype none
interface scd_stream_if #(parameter int WIDTH = 13) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> rtl/scd_sample_buffer.sv
// Small FIFO holding direct-write samples on their way to the transmit filter
`timescale 1ns/1ps
`default_nettype none
module scd_sample_buffer #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 2
) (
   input wire logic aclk,     // Master clock
   input wire logic aresetn,  // Synchronous reset, active low
   scd_stream_if.snk in_s,    // Filling side
   scd_stream_if.src out_s    // Draining side
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   logic push;
   logic pop;

   assign in_s.ready = (cnt_q != CW'(DEPTH));
   assign out_s.valid = (cnt_q != '0);
   assign out_s.data = mem_q[rd_q];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   always_ff @(posedge aclk) begin
      if (push) begin
         mem_q[wr_q] <= in_s.data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= bump(wr_q);
         end
         if (pop) begin
            rd_q <= bump(rd_q);
         end
         cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
      end
   end

   fifo_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cnt_q <= CW'(DEPTH)) else $error("sample buffer count above depth");
   fifo_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (pop && !push && cnt_q == CW'(2)) |=> (out_s.valid && cnt_q == CW'(1)))
      else $error("sample buffer lost a word on pop");
endmodule // scd_sample_buffer
`default_nettype wire

// >>> rtl/scd_clock_divider.sv
// Sample clock dividers and transmit direct-write port behind an AXI4-Lite slave
// Operation
// - Divider registers reachable only while transmit config bit 5 is low.
// - Upper nibble is transmit ratio code+4, held at 16 for codes above 12; sample MCLK/(16r), symbol MCLK/(128r).
// - Lower nibble is receive ratio code+4, held at 16 for codes above 12; receive sample clock MCLK/(16r).
// - Voice divider bits 3:0 give 16 down to 9; bit 3 set gives 8.
// - Voice divider resets to code 0111, divide by nine.
// - Direct-write range reaches the filter only while config bit 5 is high.
// - Direct writes with address bit 4 clear go to I, else Q.
// - Sample bits 11:8 come from address bits 3:0, bits 7:0 from data.
// - Each assembled sample goes through a two-entry buffer to the selected transmit filter input.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module scd_clock_divider import scd_pkg::*; #(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,                 // Master clock
   input wire logic aresetn,              // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] awaddr,  // Write address
   input wire logic [2:0] awprot,         // Unused protection bits
   input wire logic awvalid,              // Write address valid
   output logic awready,                  // Write address ready
   input wire logic [31:0] wdata,         // Write data
   input wire logic [3:0] wstrb,          // Write byte strobes
   input wire logic wvalid,               // Write data valid
   output logic wready,                   // Write data ready
   output logic [1:0] bresp,              // Write response
   output logic bvalid,                   // Write response valid
   input wire logic bready,               // Write response ready
   input wire logic [ADDR_W-1:0] araddr,  // Read address
   input wire logic [2:0] arprot,         // Unused protection bits
   input wire logic arvalid,              // Read address valid
   output logic arready,                  // Read address ready
   output logic [31:0] rdata,             // Read data
   output logic [1:0] rresp,              // Read response
   output logic rvalid,                   // Read data valid
   input wire logic rready,               // Read data ready
   output logic tx_sample_clk,            // Transmit sample clock
   output logic tx_symbol_clk,            // Transmit symbol clock
   output logic rx_sample_clk,            // Receive sample clock
   output logic voice_sample_clk,         // Voice codec sample clock
   output logic direct_write_mode,        // Range routed to the filter
   output logic filt_valid,               // Sample offered to the filter
   input wire logic filt_ready,           // Filter takes the sample
   output logic [SMP_W-1:0] filt_data,    // Sample value
   output logic filt_is_q                 // Sample is for the Q channel
);
   logic [7:0] cfg_q;
   logic [7:0] trx_div_q;
   logic [7:0] voice_div_q;
   scd_wstate_t wst_q;
   logic aw_got_q;
   logic w_got_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   scd_kind_t wkind;
   scd_kind_t rkind;
   logic [7:0] widx;
   logic exec_go;
   logic dw_push;

   scd_stream_if #(.WIDTH(SMP_W + 1)) push_if ();
   scd_stream_if #(.WIDTH(SMP_W + 1)) pop_if ();

   function automatic logic [7:0] addr_idx(input logic [ADDR_W-1:0] a);
      return 8'(a >> 2);
   endfunction

   function automatic scd_kind_t decode(input logic [7:0] idx, input logic dw);
      scd_kind_t k;
      k = K_NONE;
      if (idx == IDX_TX_CFG) begin
         k = K_CFG;
      end else if (dw && idx >= IDX_DW_I_BASE && idx <= IDX_DW_LAST) begin
         k = K_DW;
      end else if (!dw && idx == IDX_TRX_DIV) begin
         k = K_TRX;
      end else if (!dw && idx == IDX_VOICE_DIV) begin
         k = K_VOICE;
      end
      return k;
   endfunction

   function automatic logic [4:0] trx_ratio(input logic [3:0] code);
      return (code > TRX_CODE_MAX) ? TRX_RATIO_MAX : 5'(code + TRX_RATIO_OFS);
   endfunction

   function automatic logic [4:0] voice_ratio(input logic [3:0] code);
      return code[3] ? VOICE_RATIO_MIN : 5'(VOICE_RATIO_TOP - {2'b00, code[2:0]});
   endfunction

   assign direct_write_mode = cfg_q[CFG_DW_BIT];
   assign widx = addr_idx(awaddr_q);
   assign wkind = decode(widx, direct_write_mode);
   assign rkind = decode(addr_idx(araddr), direct_write_mode);

   // Write channel: address and data in either order, then execute, then respond
   assign awready = (wst_q == W_IDLE) && !aw_got_q;
   assign wready = (wst_q == W_IDLE) && !w_got_q;
   assign dw_push = (wst_q == W_EXEC) && (wkind == K_DW) && wstrb_q[0];
   assign exec_go = !dw_push || push_if.ready;
   assign bvalid = (wst_q == W_RESP);
   assign bresp = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         awaddr_q <= '0;
      end else if (awvalid && awready) begin
         aw_got_q <= 1'b1;
         awaddr_q <= awaddr;
      end else if (wst_q == W_EXEC && exec_go) begin
         aw_got_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (wvalid && wready) begin
         w_got_q <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (wst_q == W_EXEC && exec_go) begin
         w_got_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst_q <= W_IDLE;
         bresp_q <= RESP_OKAY;
      end else begin
         unique case (wst_q)
            W_IDLE: begin
               if (aw_got_q && w_got_q) begin
                  wst_q <= W_EXEC;
               end
            end
            W_EXEC: begin
               if (exec_go) begin
                  wst_q <= W_RESP;
                  bresp_q <= (wkind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
               end
            end
            W_RESP: begin
               if (bready) begin
                  wst_q <= W_IDLE;
               end
            end
            default: begin
               wst_q <= W_IDLE;
            end
         endcase
      end
   end

   // Register stores; byte lane 0 carries every field
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= TX_CFG_RST;
         trx_div_q <= TRX_DIV_RST;
         voice_div_q <= VOICE_DIV_RST;
      end else if (wst_q == W_EXEC && exec_go && wstrb_q[0]) begin
         if (wkind == K_CFG) begin
            cfg_q <= wdata_q[7:0];
         end
         if (wkind == K_TRX) begin
            trx_div_q <= wdata_q[7:0];
         end
         if (wkind == K_VOICE) begin
            voice_div_q <= wdata_q[7:0];
         end
      end
   end

   // Direct-write samples into the buffer towards the filter
   assign push_if.valid = dw_push;
   assign push_if.data = {widx[DW_CHAN_BIT], widx[3:0], wdata_q[7:0]};

   scd_sample_buffer #(.WIDTH(SMP_W + 1), .DEPTH(2)) u_buf (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_s(push_if),
      .out_s(pop_if)
   );

   assign pop_if.ready = filt_ready;
   assign filt_valid = pop_if.valid;
   assign filt_data = pop_if.data[SMP_W-1:0];
   assign filt_is_q = pop_if.data[SMP_W];

   // Read channel: one outstanding read, answered the cycle after the address
   assign arready = !rvalid_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= (rkind == K_NONE || rkind == K_DW) ? RESP_SLVERR : RESP_OKAY;
         unique case (rkind)
            K_CFG: rdata_q <= {24'h000000, cfg_q};
            K_TRX: rdata_q <= {24'h000000, trx_div_q};
            K_VOICE: rdata_q <= {24'h000000, voice_div_q};
            default: rdata_q <= '0;
         endcase
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Sample clock dividers: index 0 transmit, 1 receive, 2 voice
   logic [CNT_W-1:0] per_new [3];
   logic [CNT_W-1:0] per_q [3];
   logic [CNT_W-1:0] cnt_q [3];
   logic [2:0] clk_q;
   logic [2:0] wrap;
   logic [2:0] sym_cnt_q;
   logic sym_clk_q;

   assign per_new[0] = CNT_W'({trx_ratio(trx_div_q[TX_CODE_LSB +: 4]), 4'h0});
   assign per_new[1] = CNT_W'({trx_ratio(trx_div_q[RX_CODE_LSB +: 4]), 4'h0});
   assign per_new[2] = CNT_W'({voice_ratio(voice_div_q[3:0]), 7'h00});

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         wrap[i] = ({1'b0, cnt_q[i]} + 13'h0001) >= {1'b0, per_q[i]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 3; i++) begin
            cnt_q[i] <= '0;
            per_q[i] <= '0;
         end
         clk_q <= '0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (wrap[i]) begin
               cnt_q[i] <= '0;
               per_q[i] <= per_new[i];
               clk_q[i] <= 1'b1;
            end else begin
               cnt_q[i] <= CNT_W'(cnt_q[i] + 1'b1);
               clk_q[i] <= CNT_W'(cnt_q[i] + 1'b1) < (per_q[i] >> 1);
            end
         end
      end
   end

   // Symbol clock: eight transmit sample periods, high for the first four
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sym_cnt_q <= '0;
         sym_clk_q <= 1'b0;
      end else if (wrap[0]) begin
         sym_cnt_q <= 3'(sym_cnt_q + 1'b1);
         sym_clk_q <= 3'(sym_cnt_q + 1'b1) < 3'(SYM_PER_SMP / 2);
      end
   end

   assign tx_sample_clk = clk_q[0];
   assign rx_sample_clk = clk_q[1];
   assign voice_sample_clk = clk_q[2];
   assign tx_symbol_clk = sym_clk_q;

   // Checks
   sequence dw_exec_s;
      (wst_q == W_EXEC) && dw_push && push_if.ready;
   endsequence

   sequence div_exec_s;
      (wst_q == W_EXEC) && exec_go && wstrb_q[0] && direct_write_mode;
   endsequence

   sequence dw_into_empty_s;
      (wst_q == W_EXEC) && dw_push && push_if.ready && !filt_valid;
   endsequence

   sequence div_store_s;
      (wst_q == W_EXEC) && exec_go && wstrb_q[0] && !direct_write_mode;
   endsequence

   property hidden_div_p;
      @(posedge aclk) disable iff (!aresetn) div_exec_s |=> ($stable(trx_div_q) && $stable(voice_div_q));
   endproperty

   div_hidden_a: assert property (hidden_div_p) else $error("divider changed in direct-write mode");
   dw_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
      push_if.valid |-> (direct_write_mode && widx >= IDX_DW_I_BASE)) else $error("push outside direct-write mode");
   tx_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap[0] |=> per_q[0] == CNT_W'(16 * trx_ratio($past(trx_div_q[7:4])))) else $error("tx period wrong");
   rx_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap[1] |=> per_q[1] == CNT_W'(16 * trx_ratio($past(trx_div_q[3:0])))) else $error("rx period wrong");
   voice_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap[2] |=> per_q[2] == CNT_W'(128 * voice_ratio($past(voice_div_q[3:0])))) else $error("voice period wrong");
   voice_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> voice_div_q == 8'h07) else $error("voice divider reset value wrong");
   chan_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dw_exec_s |-> push_if.data[SMP_W] == (widx >= IDX_DW_Q_BASE)) else $error("wrong channel");
   // A sample pushed into an empty buffer is the next one offered to the filter
   sample_build_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dw_into_empty_s |=> (filt_valid && filt_data == {$past(widx[3:0]), $past(wdata_q[7:0])}))
      else $error("sample bits wrong");
   q_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dw_into_empty_s |=> (filt_is_q == ($past(widx) >= IDX_DW_Q_BASE))) else $error("sample on wrong channel");
   symbol_align_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(tx_symbol_clk) |-> $rose(tx_sample_clk)) else $error("symbol clock not aligned");
   period_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !wrap[0] |=> $stable(per_q[0])) else $error("tx period changed mid-period");
   wide_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(voice_sample_clk) |=> voice_sample_clk [*8]) else $error("voice clock pulse too short");
   tx_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(tx_sample_clk) |=> tx_sample_clk [*8]) else $error("tx clock pulse too short");
   rx_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(rx_sample_clk) |=> rx_sample_clk [*8]) else $error("rx clock pulse too short");
   rx_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !wrap[1] |=> $stable(per_q[1])) else $error("rx period changed mid-period");
   voice_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !wrap[2] |=> $stable(per_q[2])) else $error("voice period changed mid-period");
   sym_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(tx_symbol_clk) |-> $past(wrap[0])) else $error("symbol clock moved between sample periods");

   // Register side
   trx_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (div_store_s ##0 (wkind == K_TRX)) |=> trx_div_q == $past(wdata_q[7:0]))
      else $error("tx/rx divider write lost");
   voice_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (div_store_s ##0 (wkind == K_VOICE)) |=> voice_div_q == $past(wdata_q[7:0]))
      else $error("voice divider write lost");
   dw_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && rkind == K_DW) |=> (rvalid && rresp == RESP_SLVERR && rdata == '0))
      else $error("direct-write range answered a read");
endmodule // scd_clock_divider
`default_nettype wire

// >>> tb/scd_filter_sink.sv
// Transmit filter input model that takes samples with optional random stalls
`timescale 1ns/1ps
`default_nettype none
module scd_filter_sink import scd_pkg::*; (
   input wire logic aclk,                 // Master clock
   input wire logic aresetn,              // Synchronous reset, active low
   input wire logic slow,                 // Stall most cycles when high
   input wire logic filt_valid,           // Sample offered
   input wire logic [SMP_W-1:0] filt_data, // Sample value
   input wire logic filt_is_q,            // Q channel flag
   output var logic filt_ready            // Sample taken
);
   logic [SMP_W:0] got_q[$];

   // Record every accepted sample with its channel flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filt_ready <= 1'b0;
      end else begin
         if (filt_valid && filt_ready) begin
            got_q.push_back({filt_is_q, filt_data});
         end
         filt_ready <= slow ? ($urandom % 4 == 0) : 1'b1;
      end
   end
endmodule // scd_filter_sink
`default_nettype wire

// >>> tb/test_sample_clock_divider_direct_write.sv
// Self-checking bench for the sample clock divider and direct-write port
`timescale 1ns/1ps
`default_nettype none
module test_sample_clock_divider_direct_write import scd_pkg::*;;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata;
   logic awready, wready, bvalid, arready, rvalid, filt_valid, filt_ready, filt_is_q, dwm;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   logic [SMP_W-1:0] filt_data;
   logic tsc, tsy, rsc, vsc;
   logic [SMP_W:0] exp_q[$];
   int bad_count, samples_checked, i, p, tc, rc, vc;
   logic [7:0] idx, dv, div1;
   localparam logic [11:0] A_CFG = {2'b00, IDX_TX_CFG, 2'b00};
   localparam logic [11:0] A_TRX = {2'b00, IDX_TRX_DIV, 2'b00};
   localparam logic [11:0] A_VOI = {2'b00, IDX_VOICE_DIV, 2'b00};

   scd_clock_divider uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .tx_sample_clk(tsc), .tx_symbol_clk(tsy),
      .rx_sample_clk(rsc), .voice_sample_clk(vsc), .direct_write_mode(dwm),
      .filt_valid(filt_valid), .filt_ready(filt_ready), .filt_data(filt_data), .filt_is_q(filt_is_q));

   scd_filter_sink sink (.aclk(aclk), .aresetn(aresetn), .slow(slow), .filt_valid(filt_valid),
      .filt_data(filt_data), .filt_is_q(filt_is_q), .filt_ready(filt_ready));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic timeout();
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
      print_verdict();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      int n;
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 3000; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            break;
         end
      end
      if (n >= 3000) timeout();
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            break;
         end
      end
      if (n >= 100) timeout();
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return tsc;
         1: return tsy;
         2: return rsc;
         default: return vsc;
      endcase
   endfunction

   // Second full period after the call, so a freshly written ratio has landed
   task automatic measure(input int sel, output int per);
      int n, t0, k;
      logic prev, cur;
      prev = 1'b1;
      t0 = -1;
      per = 0;
      k = 0;
      for (n = 0; n < 9000; n++) begin
         @(posedge aclk);
         cur = pick(sel);
         if (cur === 1'b1 && prev === 1'b0) begin
            if (t0 >= 0) per = n - t0;
            t0 = n;
            k++;
            if (k == 3) break;
         end
         prev = cur;
      end
      if (k < 3) timeout();
   endtask

   task automatic reg_expect(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      axi_read(a, rd, rs);
      check(rd, d);
      check(rs, r);
   endtask

   initial begin
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
      bready = 1'b1; rready = 1'b1; slow = 1'b0;
      awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0;
      void'($urandom(32'hEF4994ED));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      reg_expect(A_CFG, 32'h0, RESP_OKAY);
      reg_expect(A_TRX, 32'h0, RESP_OKAY);
      reg_expect(A_VOI, 32'h7, RESP_OKAY);
      measure(0, p); check(p, 64);
      measure(1, p); check(p, 512);
      measure(2, p); check(p, 64);
      measure(3, p); check(p, 128 * 9);
      for (i = 0; i < 3; i++) begin
         tc = (i == 0) ? 12 : $urandom % 13;
         rc = (i == 0) ? 0 : $urandom % 13;
         div1 = 8'(tc * 16 + rc);
         axi_write(A_TRX, div1, rs); check(rs, RESP_OKAY);
         reg_expect(A_TRX, {24'h0, div1}, RESP_OKAY);
         measure(0, p); check(p, 16 * (tc + 4));
         measure(1, p); check(p, 128 * (tc + 4));
         measure(2, p); check(p, 16 * (rc + 4));
      end
      for (i = 0; i < 3; i++) begin
         vc = (i == 0) ? 0 : (i == 1) ? 15 : $urandom % 8;
         axi_write(A_VOI, 8'(vc), rs); check(rs, RESP_OKAY);
         measure(3, p); check(p, 128 * ((vc >= 8) ? 8 : 16 - vc));
      end
      axi_write(12'h004, 8'h55, rs); check(rs, RESP_SLVERR);
      reg_expect(12'h004, 32'h0, RESP_SLVERR);
      axi_write(A_CFG, 8'h20, rs); check(rs, RESP_OKAY);
      check(dwm, 1'b1);
      reg_expect(A_TRX, 32'h0, RESP_SLVERR);
      slow <= 1'b1;
      for (i = 0; i < 14; i++) begin
         idx = (i == 0) ? 8'h60 : (i == 1) ? 8'h7F : 8'(8'h60 + $urandom % 32);
         dv = 8'($urandom);
         axi_write({2'b00, idx, 2'b00}, dv, rs); check(rs, RESP_OKAY);
         exp_q.push_back({idx[4], idx[3:0], dv});
      end
      for (i = 0; i < 2000 && sink.got_q.size() < exp_q.size(); i++) @(posedge aclk);
      if (i >= 2000) timeout();
      check(sink.got_q.size(), exp_q.size());
      for (i = 0; i < exp_q.size() && i < sink.got_q.size(); i++) begin
         check(sink.got_q[i], exp_q[i]);
      end
      slow <= 1'b0;
      axi_write(A_CFG, 8'h00, rs); check(rs, RESP_OKAY);
      check(dwm, 1'b0);
      reg_expect(A_TRX, {24'h0, div1}, RESP_OKAY);
      reg_expect(A_VOI, {24'h0, 8'(vc)}, RESP_OKAY);
      print_verdict();
   end
endmodule // test_sample_clock_divider_direct_write
`default_nettype wire
